// ### src/sor_router.sv
/*
 * System output signal router: builds zone, home, pause, ready, run and
 * self-correct flags, packs the status word and routes six flags to four
 * output ports with per-signal polarity.
 * Assumes motion, sequencer and alarm logic on core_clk; pin inputs
 * (home, start, abort, current-off, pause, pause-clear) are asynchronous.
 * Selects are kept by outside nonvolatile storage and sampled on reset.
 */
// How it works
// - select zero drives no port
// - new selects apply only after reset
// - zone on when position within area bounds
// - home flag after homing, when command zero
// - pause flag set by pause command/input
// - pause flag cleared by resume, clear, start, motion command
// - ready off when moving, fault, inputs, unexcited
// - ready off after power-up, abort not toggle
// - run flag equals sequences executing
// - self-correct set on corrected deviation
// - self-correct cleared by motion or current-off
// - each routed flag uses own polarity
// - status word bits zero through ten
// - flags kept regardless of port assignment
// - general outputs reported apart from status
// - assigned port ignores general output writes
`timescale 1ns/10ps
module sor_router (
   // clock and reset
   input  wire logic                      core_clk,
   input  wire logic                      nrst,
   // motion and alarm state
   input  wire logic                      motion_active,
   input  wire logic                      seq_running,
   input  wire logic                      motor_excited,
   input  wire logic                      fault_flag,
   input  wire logic                      temp_warning,
   input  wire logic                      stepout_flag,
   input  wire logic                      warning_flag,
   input  wire logic signed [31:0]        shaft_position,
   input  wire logic signed [31:0]        area_bound_1,
   input  wire logic signed [31:0]        area_bound_2,
   input  wire logic signed [31:0]        position_command,
   input  wire logic                      homing_done,
   // command strobes, one cycle each
   input  wire logic                      pause_command,
   input  wire logic                      resume_command,
   input  wire logic                      pause_clear_command,
   input  wire logic                      motion_command,
   input  wire logic                      deviation_corrected,
   // pin inputs
   input  wire logic                      pause_input,
   input  wire logic                      pause_clear_input,
   input  wire logic                      start_input,
   input  wire logic                      home_input,
   input  wire logic                      abort_input,
   input  wire logic                      current_off_input,
   // configuration
   input  wire logic                      encoder_fitted,
   input  wire logic                      selfcorrect_enable,
   input  wire logic                      start_input_behaviour,
   input  wire logic [2:0]                zone_port_select,
   input  wire logic [2:0]                home_flag_port_select,
   input  wire logic [2:0]                pause_flag_port_select,
   input  wire logic [2:0]                ready_port_select,
   input  wire logic [2:0]                run_port_select,
   input  wire logic [2:0]                selfcorrect_port_select,
   input  wire logic                      zone_polarity,
   input  wire logic                      home_flag_polarity,
   input  wire logic                      pause_flag_polarity,
   input  wire logic                      ready_polarity,
   input  wire logic                      run_polarity,
   input  wire logic                      selfcorrect_polarity,
   // general purpose outputs
   input  wire logic [3:0]                gp_out_value,
   // results
   output logic [sor_pkg::STAT_W-1:0]     system_output_status_word,
   output logic [sor_pkg::NUM_PORTS-1:0]  gp_out_status,
   output logic [sor_pkg::NUM_PORTS-1:0]  out_port
);
   localparam int NR = sor_pkg::NUM_ROUTED;
   localparam int NP = sor_pkg::NUM_PORTS;
   localparam int SW = sor_pkg::SEL_W;

   // synchronised pin levels
   logic pause_in_s, pclr_in_s, start_in_s, home_in_s, abort_in_s, current_off_input_in_s;

   // four flops per pin; a level counts once stages two and three agree
   sor_sync u_sync_pause (
      .core_clk  (core_clk),
      .nrst      (nrst),
      .pin_in    (pause_input),
      .level_out (pause_in_s)
   );
   sor_sync u_sync_pclr (
      .core_clk  (core_clk),
      .nrst      (nrst),
      .pin_in    (pause_clear_input),
      .level_out (pclr_in_s)
   );
   sor_sync u_sync_start (
      .core_clk  (core_clk),
      .nrst      (nrst),
      .pin_in    (start_input),
      .level_out (start_in_s)
   );
   sor_sync u_sync_home (
      .core_clk  (core_clk),
      .nrst      (nrst),
      .pin_in    (home_input),
      .level_out (home_in_s)
   );
   sor_sync u_sync_abort (
      .core_clk  (core_clk),
      .nrst      (nrst),
      .pin_in    (abort_input),
      .level_out (abort_in_s)
   );
   sor_sync u_sync_current_off_input (
      .core_clk  (core_clk),
      .nrst      (nrst),
      .pin_in    (current_off_input),
      .level_out (current_off_input_in_s)
   );

   // edge memory for pin events
   // these reset low, the idle level of every pin, so reset makes no false edge
   logic pause_in_d_reg, start_in_d_reg, pclr_in_d_reg, current_off_input_in_d_reg;
   logic pause_rise, start_rise, pclr_rise, current_off_input_rise;

   // latched port map, taken once after reset release
   // a select above four matches no port and so drives nothing
   logic [SW-1:0] sel_reg [NR];
   logic [SW-1:0] sel_next [NR];
   logic [NR-1:0] pol_reg, pol_next;
   logic          loaded_reg, loaded_next;
   logic [SW-1:0] sel_live [NR];
   logic [NR-1:0] pol_live;

   // flag state
   logic                        paused_reg, paused_next;
   logic                        sc_reg, sc_next;
   logic [sor_pkg::PU_W-1:0]    pu_cnt_reg, pu_cnt_next;
   logic                        pu_done_reg, pu_done_next;
   logic                        zone_now, home_now, ready_now, abort_holds;
   logic signed [31:0]          lo_bound, hi_bound;

   logic [sor_pkg::STAT_W-1:0]  stat_reg, stat_next;
   logic [NR-1:0]               flag_vec;
   logic [NP-1:0]               port_reg, port_next;
   logic [NP-1:0]               gps_reg, gps_next;

   always_comb begin
      sel_live[sor_pkg::RT_ZONE]  = zone_port_select;
      sel_live[sor_pkg::RT_HOME]  = home_flag_port_select;
      sel_live[sor_pkg::RT_PAUSE] = pause_flag_port_select;
      sel_live[sor_pkg::RT_READY] = ready_port_select;
      sel_live[sor_pkg::RT_RUN]   = run_port_select;
      sel_live[sor_pkg::RT_SC]    = selfcorrect_port_select;
      pol_live = {selfcorrect_polarity, run_polarity, ready_polarity,
                  pause_flag_polarity, home_flag_polarity, zone_polarity};
   end

   // later writes to the selects are ignored until the next reset
   always_comb begin
      sel_next    = sel_reg;
      pol_next    = pol_reg;
      loaded_next = 1'b1;
      if (!loaded_reg) begin
         sel_next = sel_live;
         pol_next = pol_live;
      end
   end

   assign pause_rise = pause_in_s & ~pause_in_d_reg;
   assign start_rise = start_in_s & ~start_in_d_reg;
   assign pclr_rise  = pclr_in_s & ~pclr_in_d_reg;
   assign current_off_input_rise = current_off_input_in_s & ~current_off_input_in_d_reg;

   // ready is the and of every release condition; any one of them holds it off
   always_comb begin
      lo_bound = (area_bound_1 < area_bound_2) ? area_bound_1 : area_bound_2;
      hi_bound = (area_bound_1 < area_bound_2) ? area_bound_2 : area_bound_1;
      zone_now = (shaft_position >= lo_bound) && (shaft_position <= hi_bound);
      home_now = homing_done && (position_command == 32'sh0000_0000);
      // toggle-mode start raises abort internally, that does not block ready
      abort_holds = abort_in_s && !(start_input_behaviour == sor_pkg::START_TOGGLE
                                    && start_in_s);
      ready_now = !motion_active && !fault_flag && !home_in_s && !start_in_s
                  && !current_off_input_in_s && motor_excited && !abort_holds && pu_done_reg;
   end

   // pause: set only while motion runs; a set in the same cycle as a clear wins
   always_comb begin
      paused_next = paused_reg;
      if (resume_command || start_rise || pause_clear_command || pclr_rise
          || motion_command) begin
         paused_next = 1'b0;
      end
      if (!motion_active && !paused_reg) begin
         paused_next = 1'b0;
      end
      if ((pause_command || pause_rise) && motion_active) begin
         paused_next = 1'b1;
      end
   end

   // self-correct: a set in the same cycle as a clear wins
   always_comb begin
      sc_next = sc_reg;
      if (motion_command || current_off_input_rise || !motor_excited) begin
         sc_next = 1'b0;
      end
      if (deviation_corrected && encoder_fitted && selfcorrect_enable) begin
         sc_next = 1'b1;
      end
   end

   // power-up hold: ready stays off until the settle count has run out
   always_comb begin
      pu_cnt_next  = pu_cnt_reg;
      pu_done_next = pu_done_reg;
      if (!pu_done_reg) begin
         if (pu_cnt_reg == sor_pkg::PU_W'(sor_pkg::POWERUP_CYCLES - 1)) begin
            pu_done_next = 1'b1;
         end else begin
            pu_cnt_next = pu_cnt_reg + 1'b1;
         end
      end
   end

   // status word is kept whether or not any flag is routed
   // bits with no flag logic here pass their inputs through one register
   always_comb begin
      stat_next = sor_pkg::STAT_RESET;
      stat_next[sor_pkg::BIT_MOVE]    = motion_active;
      stat_next[sor_pkg::BIT_RUN]     = seq_running;
      stat_next[sor_pkg::BIT_ZONE]    = zone_now;
      stat_next[sor_pkg::BIT_HOME]    = home_now;
      stat_next[sor_pkg::BIT_FAULT]   = fault_flag;
      stat_next[sor_pkg::BIT_PAUSE]   = paused_reg;
      stat_next[sor_pkg::BIT_TEMP]    = temp_warning;
      stat_next[sor_pkg::BIT_READY]   = ready_now;
      stat_next[sor_pkg::BIT_STEPOUT] = stepout_flag;
      stat_next[sor_pkg::BIT_WARN]    = warning_flag;
      stat_next[sor_pkg::BIT_SC]      = sc_reg;
   end

   assign flag_vec = {sc_reg, seq_running, ready_now, paused_reg, home_now, zone_now};

   // several flags on one port: the higher index wins
   always_comb begin
      port_next = gp_out_value;
      gps_next  = gp_out_value;
      for (int i = 0; i < NR; i++) begin
         for (int p = 0; p < NP; p++) begin
            if (sel_reg[i] != sor_pkg::SEL_NONE
                && sel_reg[i] == SW'(p + 1)) begin
               // polarity one inverts the drive, so an active-low pin rests high
               port_next[p] = flag_vec[i] ^ pol_reg[i];
               gps_next[p]  = 1'b0;
            end
         end
      end
   end

   // one register bank; every output of the block is taken from here
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < NR; i++) begin
            sel_reg[i] <= sor_pkg::SEL_NONE;
         end
         pol_reg        <= '0;
         loaded_reg     <= 1'b0;
         pause_in_d_reg <= 1'b0;
         start_in_d_reg <= 1'b0;
         pclr_in_d_reg  <= 1'b0;
         current_off_input_in_d_reg <= 1'b0;
         paused_reg     <= 1'b0;
         sc_reg         <= 1'b0;
         pu_cnt_reg     <= '0;
         pu_done_reg    <= 1'b0;
         stat_reg       <= sor_pkg::STAT_RESET;
         port_reg       <= sor_pkg::PORT_RESET;
         gps_reg        <= sor_pkg::PORT_RESET;
      end else begin
         sel_reg        <= sel_next;
         pol_reg        <= pol_next;
         loaded_reg     <= loaded_next;
         pause_in_d_reg <= pause_in_s;
         start_in_d_reg <= start_in_s;
         pclr_in_d_reg  <= pclr_in_s;
         current_off_input_in_d_reg <= current_off_input_in_s;
         paused_reg     <= paused_next;
         sc_reg         <= sc_next;
         pu_cnt_reg     <= pu_cnt_next;
         pu_done_reg    <= pu_done_next;
         stat_reg       <= stat_next;
         port_reg       <= port_next;
         gps_reg        <= gps_next;
      end
   end

   assign system_output_status_word = stat_reg;
   assign gp_out_status             = gps_reg;
   assign out_port                  = port_reg;
endmodule : sor_router

// ### src/sor_pkg.sv
/*
 * Package for the system output signal router: status word layout, port
 * select encoding, reset values and timing counts.
 * Assumes one 100 MHz core clock; nothing else is shared.
 */
package sor_pkg;
   localparam int NUM_PORTS    = 4;
   localparam int SEL_W        = 3;
   localparam int STAT_W       = 11;
   localparam int NUM_ROUTED   = 6;
   // status word bit positions
   localparam int BIT_MOVE     = 0;
   localparam int BIT_RUN      = 1;
   localparam int BIT_ZONE     = 2;
   localparam int BIT_HOME     = 3;
   localparam int BIT_FAULT    = 4;
   localparam int BIT_PAUSE    = 5;
   localparam int BIT_TEMP     = 6;
   localparam int BIT_READY    = 7;
   localparam int BIT_STEPOUT  = 8;
   localparam int BIT_WARN     = 9;
   localparam int BIT_SC       = 10;
   // routed signal indices
   localparam int RT_ZONE      = 0;
   localparam int RT_HOME      = 1;
   localparam int RT_PAUSE     = 2;
   localparam int RT_READY     = 3;
   localparam int RT_RUN       = 4;
   localparam int RT_SC        = 5;
   localparam logic [SEL_W-1:0]     SEL_NONE    = 3'h0;
   localparam logic [SEL_W-1:0]     SEL_MAX     = 3'h4;
   localparam logic [STAT_W-1:0]    STAT_RESET  = 11'h000;
   localparam logic [NUM_PORTS-1:0] PORT_RESET  = 4'h0;
   localparam logic                 START_TOGGLE = 1'b1;
   // ready is held off for a settling time after power-up
   localparam int POWERUP_US     = 10;
   localparam int CLK_MHZ        = 100;
   localparam int POWERUP_CYCLES = POWERUP_US * CLK_MHZ;
   localparam int PU_W           = 10;
endpackage : sor_pkg

// ### src/sor_sync.sv
/*
 * Three-stage synchroniser with agreement filter for one pin input.
 * Assumes the pin is asynchronous to core_clk; the first stage feeds only
 * the second.
 */
`timescale 1ns/10ps
module sor_sync (
   // clock and reset
   input  wire logic core_clk,
   input  wire logic nrst,
   // pin and clean level
   input  wire logic pin_in,
   output logic      level_out
);
   logic s1_reg, s2_reg, s3_reg, lvl_reg;
   logic lvl_next;

   always_comb begin
      lvl_next = lvl_reg;
      if (s2_reg == s3_reg) begin
         lvl_next = s3_reg;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         s1_reg  <= 1'b0;
         s2_reg  <= 1'b0;
         s3_reg  <= 1'b0;
         lvl_reg <= 1'b0;
      end else begin
         s1_reg  <= pin_in;
         s2_reg  <= s1_reg;
         s3_reg  <= s2_reg;
         lvl_reg <= lvl_next;
      end
   end

   assign level_out = lvl_reg;
endmodule : sor_sync

// ### tb/sor_router_monitor.sv
/* Checker for sor_router: status word timing and flag rules.
   Assumes it is bound to sor_router and sees only its ports. */
`timescale 1ns/10ps
module sor_router_monitor (
   // clock and reset
   input wire logic                     core_clk,
   input wire logic                     nrst,
   // levels
   input wire logic                     motion_active,
   input wire logic                     seq_running,
   input wire logic                     motor_excited,
   input wire logic                     fault_flag,
   input wire logic                     temp_warning,
   input wire logic                     stepout_flag,
   input wire logic                     warning_flag,
   input wire logic signed [31:0]       shaft_position,
   input wire logic signed [31:0]       area_bound_1,
   input wire logic signed [31:0]       area_bound_2,
   input wire logic signed [31:0]       position_command,
   input wire logic                     homing_done,
   input wire logic                     encoder_fitted,
   input wire logic                     selfcorrect_enable,
   // strobes
   input wire logic                     pause_command,
   input wire logic                     resume_command,
   input wire logic                     pause_clear_command,
   input wire logic                     motion_command,
   input wire logic                     deviation_corrected,
   // result
   input wire logic [sor_pkg::STAT_W-1:0] system_output_status_word
);
   logic [1:0] up_reg;
   logic [9:0] pu_reg;
   logic       zone_now;
   logic       home_now;
   logic       up;
   // bounds may come in either order
   assign zone_now = (shaft_position >= area_bound_1 && shaft_position <= area_bound_2) ||
                     (shaft_position >= area_bound_2 && shaft_position <= area_bound_1);
   assign home_now = homing_done && (position_command == 32'sh0);
   assign up = (up_reg == 2'h3);
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         up_reg <= 2'h0;
         pu_reg <= 10'h000;
      end else begin
         up_reg <= up ? up_reg : up_reg + 2'h1;
         pu_reg <= (pu_reg == 10'h3FF) ? pu_reg : pu_reg + 10'h001;
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   property p_zone; up |-> system_output_status_word[2] == $past(zone_now); endproperty
   a_zone: assert property (p_zone) else $error("zone bit wrong");
   property p_word;
      up |-> {system_output_status_word[9:8], system_output_status_word[6],
              system_output_status_word[4], system_output_status_word[1:0]} ==
             {$past(warning_flag), $past(stepout_flag), $past(temp_warning),
              $past(fault_flag), $past(seq_running), $past(motion_active)};
   endproperty
   a_word: assert property (p_word) else $error("status bits wrong");
   property p_home; up |-> system_output_status_word[3] == $past(home_now); endproperty
   a_home: assert property (p_home) else $error("home bit wrong");
   property p_busy;
      up && (motion_active || fault_flag || !motor_excited) |=> !system_output_status_word[7];
   endproperty
   a_busy: assert property (p_busy) else $error("ready while busy");
   property p_pwr;
      pu_reg < 10'(sor_pkg::POWERUP_CYCLES) |-> !system_output_status_word[7];
   endproperty
   a_pwr: assert property (p_pwr) else $error("ready too early");
   property p_pset; up && pause_command && motion_active |-> ##2 system_output_status_word[5];
   endproperty
   a_pset: assert property (p_pset) else $error("pause not set");
   property p_pclr;
      up && (resume_command || pause_clear_command) && !pause_command ##1 !pause_command
         |-> ##1 !system_output_status_word[5];
   endproperty
   a_pclr: assert property (p_pclr) else $error("pause not cleared");
   property p_scset;
      up && deviation_corrected && encoder_fitted && selfcorrect_enable && motor_excited
         |-> ##2 system_output_status_word[10];
   endproperty
   a_scset: assert property (p_scset) else $error("sc not set");
   property p_scclr;
      up && motion_command && !deviation_corrected ##1 !deviation_corrected
         |-> ##1 !system_output_status_word[10];
   endproperty
   a_scclr: assert property (p_scclr) else $error("sc not cleared");
endmodule : sor_router_monitor

bind sor_router sor_router_monitor u_sor_router_monitor (.*);

// ### tb/sor_equipment.sv
/* Equipment wired to the output pins; tells when it saw ready.
   Assumes ready is routed to READY_PORT with the given polarity. */
`timescale 1ns/10ps
module sor_equipment #(
   parameter int   READY_PORT = 2,
   parameter logic READY_LOW  = 1'b0
) (
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       nrst,
   // pins and view
   input  wire logic [3:0] out_port,
   output logic            ready_seen
);
   // ready_seen follows the ready pin one cycle late and is not held
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ready_seen <= 1'b0;
      end else begin
         ready_seen <= out_port[READY_PORT] ^ READY_LOW;
      end
   end
endmodule : sor_equipment

// ### tb/test_system_output_signal_router.sv
/* Bench for sor_router: routing, flags, ready and remap after reset.
   Assumes sor_pkg, the monitor and sor_equipment are compiled first. */
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module test_system_output_signal_router;
   logic core_clk, nrst, motion_active, seq_running, motor_excited, fault_flag;
   logic temp_warning, stepout_flag, warning_flag, homing_done, ready_seen;
   logic pause_command, resume_command, pause_clear_command, motion_command;
   logic deviation_corrected, pause_input, pause_clear_input, start_input;
   logic home_input, abort_input, current_off_input, encoder_fitted;
   logic selfcorrect_enable, start_input_behaviour, zone_polarity, home_flag_polarity;
   logic pause_flag_polarity, ready_polarity, run_polarity, selfcorrect_polarity;
   logic [2:0] zone_port_select, home_flag_port_select, pause_flag_port_select;
   logic [2:0] ready_port_select, run_port_select, selfcorrect_port_select;
   logic signed [31:0] shaft_position, area_bound_1, area_bound_2, position_command;
   logic [3:0] gp_out_value, gp_out_status, out_port;
   logic [sor_pkg::STAT_W-1:0] system_output_status_word;
   int err_count, cmp_count, cycles;
   sor_router u_sor_router (.*);
   sor_equipment #(.READY_PORT(2), .READY_LOW(1'b0)) u_sor_equipment (
      .core_clk(core_clk), .nrst(nrst), .out_port(out_port), .ready_seen(ready_seen));
   always #5 core_clk = ~core_clk;
   task automatic wrap_up;
      if (err_count == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : wrap_up
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 10000) begin
         err_count++;
         wrap_up();
      end
   end
   task automatic tick(input int n);
      repeat (n) @(negedge core_clk);
   endtask : tick
   task automatic do_reset;
      nrst = 1'b0;
      tick(5);
      nrst = 1'b1;
      tick(500);
      `CHK(system_output_status_word[7], 1'b0)
      tick(510);
   endtask : do_reset
   task automatic strobe(input int k);
      {deviation_corrected, motion_command, pause_clear_command, resume_command,
       pause_command} = 5'h01 << k;
      tick(1);
      {deviation_corrected, motion_command, pause_clear_command, resume_command,
       pause_command} = 5'h00;
      tick(3);
   endtask : strobe
   task automatic set_cond(input int i, input logic v);
      case (i)
         0: fault_flag = v;
         1: motor_excited = !v;
         2: home_input = v;
         3: start_input = v;
         4: abort_input = v;
         default: current_off_input = v;
      endcase
   endtask : set_cond
   task automatic t_route;
      tick(3);
      `CHK(system_output_status_word, 11'h086)
      `CHK(out_port, 4'hF)
      `CHK(gp_out_status, 4'h8)
      shaft_position = 32'sh0000_0065;
      gp_out_value = 4'h3;
      tick(3);
      `CHK(system_output_status_word, 11'h082)
      `CHK(out_port, 4'h6)
      `CHK(gp_out_status, 4'h0)
      {temp_warning, stepout_flag, warning_flag, seq_running} = 4'hE;
      tick(3);
      `CHK(system_output_status_word, 11'h3C0)
      {temp_warning, stepout_flag, warning_flag, seq_running} = 4'h1;
   endtask : t_route
   task automatic t_ready;
      // toggle mode must not excuse the abort pin itself
      start_input_behaviour = 1'b1;
      for (int i = 0; i < 6; i++) begin
         set_cond(i, 1'b1);
         tick(8);
         `CHK(out_port[2], 1'b0)
         set_cond(i, 1'b0);
         tick(8);
         `CHK(ready_seen, 1'b1)
      end
      start_input_behaviour = 1'b0;
   endtask : t_ready
   task automatic t_home;
      `CHK(system_output_status_word[3], 1'b0)
      homing_done = 1'b1;
      tick(3);
      `CHK(out_port[1], 1'b0)
      `CHK(system_output_status_word[3], 1'b1)
      position_command = 32'sh0000_0005;
      tick(3);
      `CHK(system_output_status_word[3], 1'b0)
   endtask : t_home
   task automatic t_pause;
      motion_active = 1'b1;
      strobe(0);
      `CHK(system_output_status_word[5], 1'b1)
      strobe(1);
      `CHK(system_output_status_word[5], 1'b0)
      strobe(0);
      strobe(2);
      `CHK(system_output_status_word[5], 1'b0)
      pause_input = 1'b1;
      tick(8);
      pause_input = 1'b0;
      `CHK(system_output_status_word[5], 1'b1)
      pause_clear_input = 1'b1;
      tick(8);
      pause_clear_input = 1'b0;
      `CHK(system_output_status_word[5], 1'b0)
      motion_active = 1'b0;
      strobe(0);
      `CHK(system_output_status_word[5], 1'b0)
   endtask : t_pause
   task automatic t_sc;
      strobe(4);
      `CHK(system_output_status_word[10], 1'b1)
      strobe(3);
      `CHK(system_output_status_word[10], 1'b0)
      strobe(4);
      current_off_input = 1'b1;
      tick(8);
      `CHK(system_output_status_word[10], 1'b0)
      current_off_input = 1'b0;
      selfcorrect_enable = 1'b0;
      strobe(4);
      `CHK(system_output_status_word[10], 1'b0)
      tick(8);
   endtask : t_sc
   task automatic t_remap;
      zone_port_select = 3'h4;
      ready_port_select = 3'h0;
      tick(3);
      `CHK(out_port, 4'h6)
      do_reset();
      `CHK(out_port, 4'h3)
      `CHK(gp_out_status, 4'h1)
      shaft_position = 32'sh0000_0000;
      tick(3);
      `CHK(out_port, 4'hB)
      `CHK(system_output_status_word, 11'h086)
   endtask : t_remap
   initial begin
      core_clk = 1'b0;
      {motion_active, fault_flag, temp_warning, stepout_flag, warning_flag} = 5'h00;
      {homing_done, pause_input, pause_clear_input, start_input, home_input} = 5'h00;
      {abort_input, current_off_input, start_input_behaviour} = 3'h0;
      {seq_running, motor_excited, encoder_fitted, selfcorrect_enable} = 4'hF;
      {zone_polarity, pause_flag_polarity, ready_polarity} = 3'h0;
      {run_polarity, selfcorrect_polarity} = 2'h0;
      home_flag_polarity = 1'b1;
      {deviation_corrected, motion_command, pause_clear_command, resume_command,
       pause_command} = 5'h00;
      zone_port_select = 3'h1;
      home_flag_port_select = 3'h2;
      pause_flag_port_select = 3'h0;
      ready_port_select = 3'h3;
      run_port_select = 3'h5;
      selfcorrect_port_select = 3'h0;
      shaft_position = 32'sh0000_0064;
      area_bound_1 = 32'sh0000_0064;
      area_bound_2 = -32'sh0000_0064;
      position_command = 32'sh0000_0000;
      gp_out_value = 4'hB;
      do_reset();
      t_route();
      t_ready();
      t_home();
      t_pause();
      t_sc();
      t_remap();
      wrap_up();
   end
endmodule : test_system_output_signal_router
